// >>> design/mdc_defines.svh
// Constants shared by both ends of the multichannel DAC control link.
// Assumes a 25 MHz core clock on both ends.
`ifndef MDC_DEFINES_SVH
`define MDC_DEFINES_SVH

// ==========================================================================
// Clock and timing
`define MDC_CLK_NS          40
`define MDC_TRST_MIN_NS     50
`define MDC_TRST_MAX_NS     150
`define MDC_TRST_MIN_CYC  ((`MDC_TRST_MIN_NS + `MDC_CLK_NS - 1) / `MDC_CLK_NS)
`define MDC_TRST_MAX_CYC    (`MDC_TRST_MAX_NS / `MDC_CLK_NS)
`define MDC_ACQ_US          16
`define MDC_ACQ_CYC         ((`MDC_ACQ_US * 1000) / `MDC_CLK_NS)
`define MDC_SCLK_HALF_CYC   8
`define MDC_PAR_HOLD_CYC    4

// ==========================================================================
// Serial frame layout: op[20:19], address[18:14], code[13:0], MSB first
`define MDC_FRAME_BITS      21
`define MDC_OP_WRITE        2'h0
`define MDC_OP_ACQUIRE      2'h1
`define MDC_OP_READBACK     2'h2
`define MDC_NUM_CHAN        32
`define MDC_OFFSET_CHAN     6'h20

// ==========================================================================
// Host register offsets and fields
`define MDC_REG_CTRL        8'h00
`define MDC_REG_CMD         8'h04
`define MDC_REG_STATUS      8'h08
`define MDC_REG_RDATA       8'h0c
`define MDC_REG_IRQ_STAT    8'h10
`define MDC_REG_IRQ_CLR     8'h14
`define MDC_REG_IRQ_EN      8'h18
`define MDC_CMD_KIND_LSB    25
`define MDC_CMD_OFFSEL_BIT  23
`define MDC_CMD_ALL_BIT     22
`define MDC_KIND_SERIAL     2'h0
`define MDC_KIND_PARALLEL   2'h1
`define MDC_KIND_RESET      2'h2

`endif

// >>> design/mdc_pkg.sv
// Types shared by both ends of the multichannel DAC control link.
// Assumes mdc_defines.svh holds the numeric constants.
package mdc_pkg;

  // ========================================================================
  // Device sequencing states
  typedef enum logic [1:0] {
    DEV_IDLE  = 2'b00,
    DEV_TRACK = 2'b01,
    DEV_ACQ   = 2'b10
  } mdc_dev_state_t;

  // ========================================================================
  // Host sequencing states
  typedef enum logic [1:0] {
    HST_IDLE  = 2'b00,
    HST_SER   = 2'b01,
    HST_PAR   = 2'b10,
    HST_RST   = 2'b11
  } mdc_host_state_t;

endpackage

// >>> design/mdc_link_if.sv
// Pin-level link between the DAC controller host and the DAC device.
// Assumes the host drives every input pin; pulls apply while it does not.
`timescale 1ns/1ps
interface mdc_link_if;
  // Host-driven pins before the pull resolution.
  logic       csSyncN;
  logic       wrNHost;
  logic       offsetSelHost;
  logic       acquireAll;
  logic       sclkHost;
  logic       sdinHost;
  logic       interfaceSelectHost;
  logic       trackResetNHost;
  logic       pinDriveEn;
  logic [4:0] channelAddress;
  // Device-driven pins.
  logic       sdout;
  logic       busyN;
  // Levels the device sees after its internal pulls.
  logic       wrN;
  logic       offsetSel;
  logic       interfaceSelect;
  logic       sclk;
  logic       sdin;
  logic       trackResetN;

  // Undriven pulled-down inputs read low, pulled-up ones read high.
  assign wrN             = pinDriveEn ? wrNHost : 1'b0;
  assign offsetSel       = pinDriveEn ? offsetSelHost : 1'b0;
  assign interfaceSelect = pinDriveEn ? interfaceSelectHost : 1'b0;
  assign sclk            = pinDriveEn ? sclkHost : 1'b1;
  assign sdin            = pinDriveEn ? sdinHost : 1'b1;
  assign trackResetN     = pinDriveEn ? trackResetNHost : 1'b1;

  modport device (
    input  csSyncN, wrN, offsetSel, acquireAll, sclk, sdin,
    input  interfaceSelect, trackResetN, channelAddress,
    output sdout, busyN
  );
  modport host (
    output csSyncN, wrNHost, offsetSelHost, acquireAll, sclkHost, sdinHost,
    output interfaceSelectHost, trackResetNHost, pinDriveEn, channelAddress,
    input  sdout, busyN
  );
endinterface

// >>> design/mdc_device.sv
// DAC device end: serial/parallel port, register bank, acquisition control.
// Assumes pins come from another clock domain; all are synchronised here.
//
// Contract
// R1: Active-low select is chip select or frame sync.
// R2: Host asserts write with chip select for parallel.
// R3: Offset select high targets the offset channel.
// R4: Serial clock at most 14 MHz, 20 MHz acquiring.
// R5: Serial input sampled on falling serial clock edge.
// R6: Readback bit changes on rising serial clock edge.
// R7: Interface select low parallel, high serial.
// R8: Busy low throughout acquisition, high after.
// R9: Track high: addressing a channel starts acquisition.
// R10: Track low routes analog input to channel.
// R11: Track rising edge starts the pending acquisition.
// R12: Low pulse 50 to 150 ns resets device.
// R13: Write, offset, interface select pulled low.
// R14: Serial clock, data, track pulled high.
// R15: Five-bit channel address, bit four most significant.
// R16: Acquire-all makes all 32 channels acquire.
// R17: Shorter pulse ignored, longer pulse means track.
// R18: Reset and power-on load all registers zero.
// R19: Frame carries op, address, 14-bit code.
`timescale 1ns/1ps
`include "mdc_defines.svh"
module mdc_device (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Pin link
  mdc_link_if.device       link,
  // Converted analog input code
  input  wire logic [13:0] vinCode,
  // Register update report
  output logic             codeValid,
  output logic [5:0]       codeChannel,
  output logic [13:0]      codeValue,
  // Analog routing state
  output logic             trackActive,
  output logic [5:0]       trackChannel
);
  // ========================================================================
  // Pin synchronisers
  logic [12:0] pinRaw;
  logic [12:0] syn1Q;
  logic [12:0] syn2Q;
  logic [3:0]  prevQ;
  logic [3:0]  prevD;
  logic        csN, wrN, offSel, acqAll, sclkS, sdinS, serMode, trkN;
  logic [4:0]  addrS;

  // Pulled inputs resolve to their default level in the link. [R13] [R14]
  assign pinRaw = {link.csSyncN, link.wrN, link.offsetSel, link.acquireAll,
                   link.sclk, link.sdin, link.interfaceSelect,
                   link.trackResetN, link.channelAddress};
  assign csN     = syn2Q[12];
  assign wrN     = syn2Q[11];
  assign offSel  = syn2Q[10];
  assign acqAll  = syn2Q[9];
  assign sclkS   = syn2Q[8];
  assign sdinS   = syn2Q[7];
  assign serMode = syn2Q[6];
  assign trkN    = syn2Q[5];
  assign addrS   = syn2Q[4:0];
  assign prevD   = {csN, sclkS, trkN, csN | wrN};

  // Two flops per pin, reset to pulled levels; only stage two feeds logic.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syn1Q <= 13'h11a0;
      syn2Q <= 13'h11a0;
      prevQ <= 4'hf;
    end else begin
      syn1Q <= pinRaw;
      syn2Q <= syn1Q;
      prevQ <= prevD;
    end
  end

  // ========================================================================
  // Sequencing state
  mdc_pkg::mdc_dev_state_t stateQ, stateD;
  logic [8:0]  acqCntQ, acqCntD;
  logic [2:0]  lowCntQ, lowCntD;
  logic [5:0]  tgtQ, tgtD;
  logic        allQ, allD;
  logic [20:0] shQ, shD;
  logic [4:0]  bitCntQ, bitCntD;
  logic [13:0] rbQ, rbD;
  logic        doutQ, doutD;
  logic [13:0] dacQ [0:32];
  logic [13:0] dacD [0:32];
  logic        validD;
  logic [5:0]  chanD;
  logic [13:0] valueD;
  logic        trackD;
  logic        sclkFall, sclkRise, csFall, csRise, trkRise, parFall;
  logic        pulseRst, startReq;
  logic [5:0]  startTgt;
  logic        startAll;

  assign sclkFall = prevQ[2] & ~sclkS;
  assign sclkRise = ~prevQ[2] & sclkS;
  assign csFall   = prevQ[3] & ~csN;
  assign csRise   = ~prevQ[3] & csN;
  assign trkRise  = ~prevQ[1] & trkN;
  assign parFall  = prevQ[0] & ~(csN | wrN);

  // A release after 50 to 150 ns of low is a reset; shorter is a glitch.
  assign pulseRst = trkRise && (lowCntQ >= 3'(`MDC_TRST_MIN_CYC))
                    && (lowCntQ <= 3'(`MDC_TRST_MAX_CYC)); // [R12] [R17]

  // Next-state logic for ports, registers and acquisition.
  always_comb begin
    stateD   = stateQ;
    acqCntD  = acqCntQ;
    lowCntD  = trkN ? 3'h0 : ((lowCntQ == 3'h7) ? lowCntQ : lowCntQ + 3'h1);
    tgtD     = tgtQ;
    allD     = allQ;
    shD      = shQ;
    bitCntD  = bitCntQ;
    rbD      = rbQ;
    doutD    = doutQ;
    dacD     = dacQ;
    validD   = 1'b0;
    chanD    = codeChannel;
    valueD   = codeValue;
    startReq = 1'b0;
    startTgt = tgtQ;
    startAll = 1'b0;
    trackD   = ~trkN && (lowCntQ > 3'(`MDC_TRST_MAX_CYC)); // [R10] [R17]
    if (pulseRst) begin
      // Device state and all channel registers back to power-on values; codeChannel, codeValue hold. [R12]
      stateD  = mdc_pkg::DEV_IDLE;
      acqCntD = 9'h000;
      tgtD    = 6'h00;
      allD    = 1'b0;
      shD     = 21'h000000;
      bitCntD = 5'h00;
      rbD     = 14'h0000;
      doutD   = 1'b0;
      trackD  = 1'b0;
      for (int i = 0; i <= `MDC_NUM_CHAN; i++) begin
        dacD[i] = 14'h0000; // [R18]
      end
    end else begin
      if (serMode) begin // [R7]
        // Frame sync low brackets each serial transfer. [R1]
        if (csFall) begin
          bitCntD = 5'h00;
          doutD   = rbQ[13];
          rbD     = {rbQ[12:0], 1'b0};
        end
        if (!csN && sclkFall) begin
          shD     = {shQ[19:0], sdinS}; // [R5]
          bitCntD = (bitCntQ == 5'h1f) ? bitCntQ : bitCntQ + 5'h01;
        end
        if (!csN && sclkRise) begin
          doutD = rbQ[13]; // [R6]
          rbD   = {rbQ[12:0], 1'b0};
        end
        if (csRise && bitCntQ == 5'(`MDC_FRAME_BITS)) begin
          // Only a frame of exactly the right length is acted on. [R19]
          case (shQ[20:19])
            `MDC_OP_WRITE: begin
              dacD[shQ[18:14]] = shQ[13:0];
              validD = 1'b1;
              chanD  = {1'b0, shQ[18:14]};
              valueD = shQ[13:0];
            end
            `MDC_OP_ACQUIRE: begin
              startReq = 1'b1;
              startTgt = {1'b0, shQ[18:14]};
            end
            `MDC_OP_READBACK: begin
              rbD = dacQ[shQ[18:14]];
            end
            default: begin
              rbD = rbQ;
            end
          endcase
        end
      end else if (parFall) begin
        // Write with chip select addresses a channel. [R1] [R2] [R15]
        startReq = 1'b1;
        startTgt = offSel ? `MDC_OFFSET_CHAN : {1'b0, addrS}; // [R3]
        startAll = acqAll; // [R16]
      end
      case (stateQ)
        mdc_pkg::DEV_IDLE: begin
          if (startReq) begin
            tgtD    = startTgt;
            allD    = startAll;
            acqCntD = 9'h000;
            // Track high acquires at once, low waits for release. [R9]
            stateD  = trkN ? mdc_pkg::DEV_ACQ : mdc_pkg::DEV_TRACK;
          end
        end
        mdc_pkg::DEV_TRACK: begin
          if (trkRise && lowCntQ > 3'(`MDC_TRST_MAX_CYC)) begin
            stateD = mdc_pkg::DEV_ACQ; // [R11]
          end
        end
        mdc_pkg::DEV_ACQ: begin
          acqCntD = acqCntQ + 9'h001;
          if (acqCntQ == 9'(`MDC_ACQ_CYC - 1)) begin
            stateD = mdc_pkg::DEV_IDLE;
            validD = 1'b1;
            chanD  = allQ ? 6'h3f : tgtQ;
            valueD = vinCode;
            if (allQ) begin
              for (int i = 0; i < `MDC_NUM_CHAN; i++) begin
                dacD[i] = vinCode; // [R16]
              end
            end else begin
              dacD[tgtQ] = vinCode;
            end
          end
        end
        default: begin
          stateD = mdc_pkg::DEV_IDLE;
        end
      endcase
    end
  end

  // State registers; the power-on contents are all zero. [R18]
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateQ       <= mdc_pkg::DEV_IDLE;
      acqCntQ      <= 9'h000;
      lowCntQ      <= 3'h0;
      tgtQ         <= 6'h00;
      allQ         <= 1'b0;
      shQ          <= 21'h000000;
      bitCntQ      <= 5'h00;
      rbQ          <= 14'h0000;
      doutQ        <= 1'b0;
      codeValid    <= 1'b0;
      codeChannel  <= 6'h00;
      codeValue    <= 14'h0000;
      trackActive  <= 1'b0;
      for (int i = 0; i <= `MDC_NUM_CHAN; i++) begin
        dacQ[i] <= 14'h0000;
      end
    end else begin
      stateQ       <= stateD;
      acqCntQ      <= acqCntD;
      lowCntQ      <= lowCntD;
      tgtQ         <= tgtD;
      allQ         <= allD;
      shQ          <= shD;
      bitCntQ      <= bitCntD;
      rbQ          <= rbD;
      doutQ        <= doutD;
      codeValid    <= validD;
      codeChannel  <= chanD;
      codeValue    <= valueD;
      trackActive  <= trackD;
      dacQ         <= dacD;
    end
  end

  // Busy is low for exactly the acquisition window. [R8]
  assign link.busyN  = (stateQ != mdc_pkg::DEV_ACQ);
  assign link.sdout  = doutQ;
  assign trackChannel = tgtQ;
endmodule // mdc_device

// >>> design/mdc_host.sv
// Host end: APB register slave that drives the DAC link pins.
// Assumes an APB master on core_clk and the device across the link.
`timescale 1ns/1ps
`include "mdc_defines.svh"
module mdc_host (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq,
  // Pin link
  mdc_link_if.host         link
);
  // ========================================================================
  // Device pin synchronisers
  logic [1:0] syn1Q, syn2Q;
  logic       busyPrevQ;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syn1Q     <= 2'h3;
      syn2Q     <= 2'h3;
      busyPrevQ <= 1'b1;
    end else begin
      syn1Q     <= {link.busyN, link.sdout};
      syn2Q     <= syn1Q;
      busyPrevQ <= syn2Q[1];
    end
  end

  // ========================================================================
  // Registers and sequencer
  mdc_pkg::mdc_host_state_t stateQ, stateD;
  logic [1:0]  ctrlQ, ctrlD;
  logic [20:0] shQ, shD;
  logic [13:0] rdQ, rdD;
  logic [1:0]  irqStatQ, irqStatD, irqEnQ, irqEnD;
  logic [3:0]  cntQ, cntD;
  logic [4:0]  bitQ, bitD;
  logic        csQ, csD, wrQ, wrD, sclkQ, sclkD, trkQ, trkD;
  logic        offQ, offD, allQ, allD, drvQ;
  logic [4:0]  addrQ, addrD;
  logic [31:0] rdataD;
  logic        wrEn, done;
  logic [1:0]  kind;

  assign wrEn  = psel && penable && pwrite;
  assign kind  = pwdata[`MDC_CMD_KIND_LSB +: 2];

  // Register access, command launch and pin sequencing.
  always_comb begin
    stateD = stateQ;
    ctrlD  = ctrlQ;
    shD    = shQ;
    rdD    = rdQ;
    irqEnD = irqEnQ;
    cntD   = cntQ + 4'h1;
    bitD   = bitQ;
    csD    = csQ;
    wrD    = wrQ;
    sclkD  = sclkQ;
    trkD   = trkQ;
    offD   = offQ;
    allD   = allQ;
    addrD  = addrQ;
    done   = 1'b0;
    rdataD = prdata;
    if (wrEn && paddr == `MDC_REG_CTRL) begin
      ctrlD = pwdata[1:0];
    end
    if (wrEn && paddr == `MDC_REG_IRQ_EN) begin
      irqEnD = pwdata[1:0];
    end
    case (stateQ)
      mdc_pkg::HST_IDLE: begin
        cntD = 4'h0;
        if (wrEn && paddr == `MDC_REG_CMD) begin
          shD   = pwdata[20:0];
          addrD = pwdata[18:14]; // [R15]
          offD  = pwdata[`MDC_CMD_OFFSEL_BIT]; // [R3]
          allD  = pwdata[`MDC_CMD_ALL_BIT];
          bitD  = 5'h00;
          if (kind == `MDC_KIND_SERIAL) begin
            stateD = mdc_pkg::HST_SER;
            csD    = 1'b0;
          end else if (kind == `MDC_KIND_PARALLEL) begin
            stateD = mdc_pkg::HST_PAR;
            csD    = 1'b0;
            wrD    = 1'b0; // [R2]
          end else begin
            stateD = mdc_pkg::HST_RST;
            trkD   = 1'b0;
          end
        end
      end
      mdc_pkg::HST_SER: begin
        // Half period of 8 cycles keeps the link far under 14 MHz. [R4]
        if (cntQ == 4'(`MDC_SCLK_HALF_CYC - 1)) begin
          cntD  = 4'h0;
          sclkD = ~sclkQ;
          if (sclkQ && bitQ < 5'h0e) begin
            rdD = {rdQ[12:0], syn2Q[0]};
          end
          if (!sclkQ) begin
            shD = {shQ[19:0], 1'b0}; // [R5]
            if (bitQ == 5'(`MDC_FRAME_BITS - 1)) begin
              stateD = mdc_pkg::HST_IDLE;
              csD    = 1'b1;
              sclkD  = 1'b1;
              done   = 1'b1;
            end
            bitD = bitQ + 5'h01;
          end
        end
      end
      mdc_pkg::HST_PAR: begin
        if (cntQ == 4'(`MDC_PAR_HOLD_CYC - 1)) begin
          stateD = mdc_pkg::HST_IDLE;
          csD    = 1'b1;
          wrD    = 1'b1;
          done   = 1'b1;
        end
      end
      mdc_pkg::HST_RST: begin
        // Three cycles low is 120 ns, inside the reset window. [R12]
        if (cntQ == 4'(`MDC_TRST_MAX_CYC - 1)) begin
          stateD = mdc_pkg::HST_IDLE;
          trkD   = 1'b1;
          done   = 1'b1;
        end
      end
      default: begin
        stateD = mdc_pkg::HST_IDLE;
      end
    endcase
    // Set wins over a clear in the same cycle.
    irqStatD = irqStatQ;
    if (wrEn && paddr == `MDC_REG_IRQ_CLR) begin
      irqStatD = irqStatQ & ~pwdata[1:0];
    end
    irqStatD = irqStatD | {syn2Q[1] & ~busyPrevQ, done};
    if (psel && !penable) begin
      case (paddr)
        `MDC_REG_CTRL:     rdataD = {30'h0, ctrlQ};
        `MDC_REG_STATUS:   rdataD = {29'h0, ctrlQ[1], ~syn2Q[1],
                                     stateQ != mdc_pkg::HST_IDLE};
        `MDC_REG_RDATA:    rdataD = {18'h0, rdQ};
        `MDC_REG_IRQ_STAT: rdataD = {30'h0, irqStatQ};
        `MDC_REG_IRQ_EN:   rdataD = {30'h0, irqEnQ};
        default:           rdataD = 32'h0;
      endcase
    end
  end

  // Registers only; idle pins are deselected with the clock high.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateQ   <= mdc_pkg::HST_IDLE;
      ctrlQ    <= 2'h0;
      shQ      <= 21'h000000;
      rdQ      <= 14'h0000;
      irqStatQ <= 2'h0;
      irqEnQ   <= 2'h0;
      cntQ     <= 4'h0;
      bitQ     <= 5'h00;
      csQ      <= 1'b1;
      wrQ      <= 1'b1;
      sclkQ    <= 1'b1;
      trkQ     <= 1'b1;
      offQ     <= 1'b0;
      allQ     <= 1'b0;
      addrQ    <= 5'h00;
      drvQ     <= 1'b0;
      prdata   <= 32'h0;
    end else begin
      stateQ   <= stateD;
      ctrlQ    <= ctrlD;
      shQ      <= shD;
      rdQ      <= rdD;
      irqStatQ <= irqStatD;
      irqEnQ   <= irqEnD;
      cntQ     <= cntD;
      bitQ     <= bitD;
      csQ      <= csD;
      wrQ      <= wrD;
      sclkQ    <= sclkD;
      trkQ     <= trkD;
      offQ     <= offD;
      allQ     <= allD;
      addrQ    <= addrD;
      drvQ     <= 1'b1;
      prdata   <= rdataD;
    end
  end

  // Pin drive; track hold in the control register forces the pin low.
  assign link.csSyncN             = csQ;
  assign link.wrNHost             = wrQ;
  assign link.offsetSelHost       = offQ;
  assign link.acquireAll          = allQ;
  assign link.sclkHost            = sclkQ;
  assign link.sdinHost            = shQ[20];
  assign link.interfaceSelectHost = ctrlQ[0];
  assign link.trackResetNHost     = trkQ & ~ctrlQ[1];
  assign link.pinDriveEn          = drvQ;
  assign link.channelAddress      = addrQ;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign irq     = |(irqStatQ & irqEnQ);
endmodule // mdc_host

// >>> bench/mdc_link_assertions.sv
// Concurrent checks on the pins between the DAC host and the DAC device.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ps
`include "mdc_defines.svh"
module mdc_link_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link pins as the device sees them
  input wire logic csSyncN,
  input wire logic wrN,
  input wire logic offsetSel,
  input wire logic interfaceSelect,
  input wire logic sclk,
  input wire logic sdin,
  input wire logic trackResetN,
  input wire logic pinDriveEn,
  input wire logic busyN
);
  default clocking cb @(posedge core_clk); endclocking

  // ==========================================================================
  // Helper counters
  // Counters stand in for repetition, since frames and acquisitions are long.
  logic [4:0] falls_q;
  logic [9:0] busyLow_q;
  logic       sclkPrev_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      falls_q    <= '0;
      busyLow_q  <= '0;
      sclkPrev_q <= 1'b1;
    end else begin
      sclkPrev_q <= sclk;
      busyLow_q  <= busyN ? 10'h0 : busyLow_q + 10'h1;
      if (csSyncN) falls_q <= '0;
      else if (sclkPrev_q && !sclk) falls_q <= falls_q + 5'h1;
    end
  end

  // ==========================================================================
  // Properties
  // Pull checks keep no reset guard: the host releases pins only in reset.
  sequence s_parStart; $fell(wrN); endsequence
  sequence s_parHold; (!wrN && !csSyncN) [*4] ##1 wrN; endsequence
  property p_pullLow; !pinDriveEn |-> !wrN && !offsetSel && !interfaceSelect;
  endproperty
  property p_pullHigh; !pinDriveEn |-> sclk && sdin && trackResetN;
  endproperty
  property p_sdinStable; disable iff (!rst_n) $fell(sclk) |-> $stable(sdin);
  endproperty
  property p_sclkInFrame; disable iff (!rst_n) $fell(sclk) |-> !csSyncN;
  endproperty
  property p_serialMode;
    disable iff (!rst_n) $fell(sclk) |-> interfaceSelect;
  endproperty
  property p_frameLen; disable iff (!rst_n)
    $rose(csSyncN) && falls_q != 5'h0 |-> falls_q == 5'h15;
  endproperty
  property p_parWrite; disable iff (!rst_n) s_parStart |-> s_parHold;
  endproperty
  property p_busyLen; disable iff (!rst_n)
    $rose(busyN) |-> busyLow_q == `MDC_ACQ_CYC;
  endproperty

  a_pullLow: assert property (p_pullLow)
    else $error("pulled-down pin not low");
  a_pullHigh: assert property (p_pullHigh)
    else $error("pulled-up pin not high");
  a_sdinStable: assert property (p_sdinStable)
    else $error("serial data moved at clock fall");
  a_sclkInFrame: assert property (p_sclkInFrame)
    else $error("serial clock fell outside a frame");
  a_serialMode: assert property (p_serialMode)
    else $error("serial clock ran in parallel mode");
  a_frameLen: assert property (p_frameLen)
    else $error("frame length wrong");
  a_parWrite: assert property (p_parWrite)
    else $error("parallel write strobe malformed");
  a_busyLen: assert property (p_busyLen)
    else $error("busy low span wrong");
endmodule // mdc_link_assertions

// >>> bench/multichannel_dac_host_control_tb.sv
// Bench joining host and device over the link, driven through APB.
// Assumes the host answers APB at once and the device acquires vinCode.
`timescale 1ns/1ps
`include "mdc_defines.svh"
module multichannel_dac_host_control_tb;
  logic        core_clk = 1'b0;
  logic        rst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic        codeValid, trackActive;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [13:0] vinCode, codeValue, lastVal;
  logic [5:0]  codeChannel, trackChannel, lastCh;
  logic [31:0] pcmd [3] = '{32'h0200_c000, 32'h0280_0000, 32'h0240_0000};
  logic [5:0]  pch [3] = '{6'h03, 6'h20, 6'h3f};
  int          num_errors = 0;
  int          n_compared = 0;

  mdc_link_if link ();
  mdc_host mdc_host_inst (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .link(link));
  mdc_device mdc_device_inst (.core_clk(core_clk), .rst_n(rst_n),
    .link(link), .vinCode(vinCode), .codeValid(codeValid),
    .codeChannel(codeChannel), .codeValue(codeValue),
    .trackActive(trackActive), .trackChannel(trackChannel));
  mdc_link_assertions mdc_link_assertions_inst (.core_clk(core_clk),
    .rst_n(rst_n), .csSyncN(link.csSyncN), .wrN(link.wrN),
    .offsetSel(link.offsetSel), .interfaceSelect(link.interfaceSelect),
    .sclk(link.sclk), .sdin(link.sdin), .trackResetN(link.trackResetN),
    .pinDriveEn(link.pinDriveEn), .busyN(link.busyN));

  // ==========================================================================
  // Clock and capture of the last register update
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (codeValid === 1'b1) begin
      lastCh  <= codeChannel;
      lastVal <= codeValue;
    end
  end

  // ==========================================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; read data lands in r.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Polls the sticky events, since host and device busy flags overlap loosely.
  task automatic waitEvt(input logic [31:0] m);
    int k;
    r = '0;
    for (k = 0; k < 1000 && (r & m) == 0; k++)
      apb(1'b0, `MDC_REG_IRQ_STAT, 0);
    if ((r & m) == 0) num_errors++;
    apb(1'b1, `MDC_REG_IRQ_CLR, 32'h3);
  endtask
  task automatic rb(input logic [4:0] a);
    apb(1'b1, `MDC_REG_CMD, {11'h0, 2'h2, a, 14'h0});
    waitEvt(1);
    apb(1'b1, `MDC_REG_CMD, {11'h0, 2'h2, a, 14'h0});
    waitEvt(1);
    apb(1'b0, `MDC_REG_RDATA, 0);
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog, far beyond the few thousand cycles the tests need
  initial begin
    #2000000;
    num_errors++;
    stop_test;
  end

  // ==========================================================================
  // Tests
  initial begin
    int k;
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; vinCode = '0; lastCh = '0; lastVal = '0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1'b0, `MDC_REG_STATUS, 0);
    check(r, 32'h0);
    check({31'h0, pslverr}, 32'h0);
    apb(1'b1, 8'h1c, 32'hffff_ffff);
    apb(1'b0, 8'h1c, 0);
    check(r, 32'h0);
    $display("reset test done");
    apb(1'b1, `MDC_REG_CTRL, 32'h1);
    apb(1'b1, `MDC_REG_CMD, {11'h0, 2'h0, 5'h05, 14'h1abc});
    waitEvt(1);
    check({lastCh, lastVal}, {6'h05, 14'h1abc});
    rb(5);
    check(r, 32'h1abc);
    $display("serial test done");
    apb(1'b1, `MDC_REG_IRQ_EN, 32'h2);
    vinCode <= 14'h0555;
    apb(1'b1, `MDC_REG_CMD, {11'h0, 2'h1, 5'h07, 14'h0});
    for (k = 0; k < 1000 && irq !== 1'b1; k++) @(posedge core_clk);
    @(negedge core_clk);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, `MDC_REG_IRQ_EN, 32'h0);
    repeat (2) @(negedge core_clk);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, `MDC_REG_IRQ_EN, 32'h2);
    repeat (2) @(negedge core_clk);
    check({31'h0, irq}, 32'h1);
    waitEvt(2);
    repeat (2) @(negedge core_clk);
    check({31'h0, irq}, 32'h0);
    check({lastCh, lastVal}, {6'h07, 14'h0555});
    $display("acquire test done");
    apb(1'b1, `MDC_REG_CTRL, 32'h0);
    for (k = 0; k < 3; k++) begin
      vinCode <= 14'h0100 + 14'(k);
      apb(1'b1, `MDC_REG_CMD, pcmd[k]);
      waitEvt(2);
      check({lastCh, lastVal}, {pch[k], 14'h0100 + 14'(k)});
    end
    $display("parallel test done");
    apb(1'b1, `MDC_REG_CTRL, 32'h3);
    vinCode <= 14'h0777;
    apb(1'b1, `MDC_REG_CMD, {11'h0, 2'h1, 5'h09, 14'h0});
    waitEvt(1);
    @(negedge core_clk);
    check({trackActive, trackChannel}, {1'b1, 6'h09});
    apb(1'b0, `MDC_REG_STATUS, 0);
    check(r, 32'h4);
    apb(1'b1, `MDC_REG_CTRL, 32'h1);
    waitEvt(2);
    check({lastCh, lastVal}, {6'h09, 14'h0777});
    $display("track test done");
    apb(1'b1, `MDC_REG_CMD, 32'h0400_0000);
    repeat (20) @(posedge core_clk);
    apb(1'b1, `MDC_REG_IRQ_CLR, 32'h3);
    rb(5);
    check(r, 32'h0);
    $display("reset pulse test done");
    stop_test;
  end
endmodule // multichannel_dac_host_control_tb
